// ---- include/sod_consts.vh ----
// constants for the stack operand datapath
`ifndef SOD_CONSTS_VH
`define SOD_CONSTS_VH
// --------------------------------------------------
// operation codes on op_code
// --------------------------------------------------
`define SOD_OP_NOP        4'h0
`define SOD_OP_MEM_LOAD   4'h1
`define SOD_OP_MEM_STORE  4'h2
`define SOD_OP_XBUS_LOAD  4'h3
`define SOD_OP_XBUS_STORE 4'h4
`define SOD_OP_USR_LOAD   4'h5
`define SOD_OP_USR_STORE  4'h6
`define SOD_OP_EXCHANGE   4'h7
`define SOD_OP_DUPLICATE  4'h8
`define SOD_OP_OVER       4'h9
`define SOD_OP_DISCARD    4'ha
`define SOD_OP_ALU        4'hb
`define SOD_OP_SHIFT      4'hc
`define SOD_OP_SHORT_LIT  4'hd
`define SOD_OP_LONG_LIT   4'he
// --------------------------------------------------
// instruction field positions
// --------------------------------------------------
`define SOD_RET_BIT       5
`define SOD_ADDR_MSB      4
`define SOD_BYTE_BIT      12
`define SOD_ALU_A_LSB     6
`define SOD_ALU_C_LSB     9
`define SOD_SHIFT_LSB     0
`define SOD_INV_BIT       8
// --------------------------------------------------
// register map
// --------------------------------------------------
`define SOD_REG_CTRL      4'h0
`define SOD_REG_HEAD      4'h1
`define SOD_REG_SECOND    4'h2
`define SOD_REG_DEPTH     4'h3
`define SOD_REG_STATUS    4'h4
`define SOD_CTRL_RST      16'h0000
// --------------------------------------------------
// stack memory
// --------------------------------------------------
`define SOD_STK_DEPTH     256
`define SOD_STK_AW        8
`endif

// ---- rtl/sod_stack_mem.v ----
// last-in first-out stack memory below the second operand
`timescale 1ns/1ps
module sod_stack_mem (
    // clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // push and pop
    input  wire        push,
    input  wire        pop,
    input  wire [15:0] push_data,
    // state
    output wire [15:0] top_data,
    output wire [8:0]  depth
);
`include "sod_consts.vh"
    reg  [15:0] mem_ff [0:`SOD_STK_DEPTH-1];
    reg  [8:0]  ptr_ff;
    wire [7:0]  top_idx = ptr_ff[7:0] - 8'h01;
    genvar i;

    // --------------------------------------------------
    // storage, one entry per generate step
    // --------------------------------------------------
    generate
        for (i = 0; i < `SOD_STK_DEPTH; i = i + 1)
        begin : g_ent
            always @(posedge clk)
            begin
                if (sys_rst)
                    mem_ff[i] <= 16'h0000;
                else if (push && !pop && ptr_ff != 9'h100 && ptr_ff[7:0] == i)
                    mem_ff[i] <= push_data;
                else if (push && pop && top_idx == i)
                    mem_ff[i] <= push_data;
            end
        end
    endgenerate

    always @(posedge clk)
    begin
        if (sys_rst)
            ptr_ff <= 9'h000;
        else if (push && !pop && ptr_ff != 9'h100)
            ptr_ff <= ptr_ff + 9'h001;
        else if (pop && !push && ptr_ff != 9'h000)
            ptr_ff <= ptr_ff - 9'h001;
    end

    assign top_data = (ptr_ff == 9'h000) ? 16'h0000 : mem_ff[top_idx];
    assign depth    = ptr_ff;
endmodule

// ---- rtl/sod_datapath.v ----
// stack operand datapath: head and second operand registers with stack memory
// What this block does
// - memory load: address in head, result to head
// - memory store: second operand to address in head
// - extension-bus load by field into head
// - peripheral registers readable by same load
// - extension-bus store of head by field
// - peripheral registers writable by same store
// - user load: full word into head
// - user store: full head word
// - exchange swaps head and second operand
// - duplicate copies head, pushes old second
// - over: second to head, push chain
// - discard pops stack into head chain
// - invert bit complements head value, except on stores, shift and literals
// - ALU step on head and second
// - shift step on head, second, or both
// - short literal push with register movement
// - long literal from next program word
// - return bit adds subroutine return
// - read data latched into second operand first
// - bit five is the return bit
// - return pops return stack, restores page
// - short literal is unsigned 0 to 31
`timescale 1ns/1ps
module sod_datapath (
    // clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // instruction issue
    input  wire        op_valid,
    input  wire [3:0]  op_code,
    input  wire [15:0] instr,
    input  wire [15:0] long_lit,
    // main memory
    output reg  [15:0] mem_addr_ff,
    output reg  [15:0] mem_wdata_ff,
    output reg         mem_rd_ff,
    output reg         mem_wr_ff,
    output reg         mem_byte_ff,
    input  wire [15:0] mem_rdata,
    // extension bus and peripherals
    output reg  [4:0]  xbus_addr_ff,
    output reg  [15:0] xbus_wdata_ff,
    output reg         xbus_rd_ff,
    output reg         xbus_wr_ff,
    input  wire [15:0] xbus_rdata,
    // user space
    output reg  [4:0]  usr_addr_ff,
    output reg  [15:0] usr_wdata_ff,
    output reg         usr_rd_ff,
    output reg         usr_wr_ff,
    input  wire [15:0] usr_rdata,
    // external function units
    output wire [3:0]  alu_c,
    output wire [2:0]  alu_a,
    output wire [3:0]  shift_sel,
    input  wire [15:0] alu_result,
    input  wire [15:0] shift_head,
    input  wire [15:0] shift_second,
    // return sequencing
    output reg         ret_req_ff,
    output reg         ret_pop_ff,
    output reg         pc_from_index_ff,
    output reg         page_from_saved_page_reg_ff,
    // register port
    input  wire [3:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata_ff,
    // state
    output wire        busy,
    output wire [15:0] head,
    output wire [15:0] second
);
`include "sod_consts.vh"
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_FIN  = 2'h2;

    reg  [15:0] head_ff;
    reg  [15:0] nxt_head;
    reg  [15:0] second_ff;
    reg  [15:0] nxt_second;
    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    reg  [3:0]  pend_op_ff;
    reg         pend_inv_ff;
    reg  [15:0] ctrl_ff;
    reg  [15:0] op_count_ff;
    reg         push;
    reg         pop;
    reg  [15:0] push_data;
    reg  [15:0] rd_word;
    wire [15:0] stk_top;
    wire [8:0]  stk_depth;
    wire        inv = instr[`SOD_INV_BIT];
    wire        issue = op_valid && state_ff == ST_IDLE;
    wire        is_load = op_code == `SOD_OP_MEM_LOAD || op_code == `SOD_OP_XBUS_LOAD ||
                          op_code == `SOD_OP_USR_LOAD;

    // --------------------------------------------------
    // stack memory
    // --------------------------------------------------
    sod_stack_mem u_stk (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .push      (push),
        .pop       (pop),
        .push_data (push_data),
        .top_data  (stk_top),
        .depth     (stk_depth)
    );

    assign alu_c     = instr[`SOD_ALU_C_LSB+3:`SOD_ALU_C_LSB];
    assign alu_a     = instr[`SOD_ALU_A_LSB+2:`SOD_ALU_A_LSB];
    assign shift_sel = instr[`SOD_SHIFT_LSB+3:`SOD_SHIFT_LSB];
    assign busy      = state_ff != ST_IDLE;
    assign head      = head_ff;
    assign second    = second_ff;

    // --------------------------------------------------
    // read word selection for the wait cycle
    // --------------------------------------------------
    always @*
    begin
        case (pend_op_ff)
            `SOD_OP_MEM_LOAD:  rd_word = mem_rdata;
            `SOD_OP_XBUS_LOAD: rd_word = xbus_rdata;
            `SOD_OP_USR_LOAD:  rd_word = usr_rdata;
            default:           rd_word = 16'h0000;
        endcase
    end

    // --------------------------------------------------
    // next state of head, second and stack
    // --------------------------------------------------
    always @*
    begin
        nxt_head   = head_ff;
        nxt_second = second_ff;
        nxt_state  = state_ff;
        push       = 1'b0;
        pop        = 1'b0;
        push_data  = second_ff;
        case (state_ff)
            ST_IDLE:
            begin
                if (op_valid)
                begin
                    case (op_code)
                        `SOD_OP_MEM_LOAD, `SOD_OP_XBUS_LOAD, `SOD_OP_USR_LOAD:
                            nxt_state = ST_WAIT;
                        `SOD_OP_MEM_STORE:
                        begin
                            nxt_head   = second_ff;
                            nxt_second = stk_top;
                            pop        = 1'b1;
                        end
                        `SOD_OP_XBUS_STORE, `SOD_OP_USR_STORE:
                        begin
                            nxt_head   = second_ff;
                            nxt_second = stk_top;
                            pop        = 1'b1;
                        end
                        `SOD_OP_EXCHANGE:
                        begin
                            nxt_head   = inv ? ~second_ff : second_ff;
                            nxt_second = head_ff;
                        end
                        `SOD_OP_DUPLICATE:
                        begin
                            nxt_second = head_ff;
                            nxt_head   = inv ? ~head_ff : head_ff;
                            push       = 1'b1;
                        end
                        `SOD_OP_OVER:
                        begin
                            nxt_head   = inv ? ~second_ff : second_ff;
                            nxt_second = head_ff;
                            push       = 1'b1;
                        end
                        `SOD_OP_DISCARD:
                        begin
                            nxt_head   = inv ? ~second_ff : second_ff;
                            nxt_second = stk_top;
                            pop        = 1'b1;
                        end
                        `SOD_OP_ALU:
                            nxt_head   = inv ? ~alu_result : alu_result;
                        `SOD_OP_SHIFT:
                        begin
                            nxt_head   = shift_head;
                            nxt_second = shift_second;
                        end
                        `SOD_OP_SHORT_LIT:
                        begin
                            nxt_head   = {11'h000, instr[4:0]};
                            nxt_second = head_ff;
                            push       = 1'b1;
                        end
                        `SOD_OP_LONG_LIT:
                        begin
                            nxt_head   = long_lit;
                            nxt_second = head_ff;
                            push       = 1'b1;
                        end
                        default:
                            nxt_head   = inv ? ~head_ff : head_ff;
                    endcase
                end
            end
            ST_WAIT:
            begin
                // old second saved below so the finishing pop restores it
                nxt_second = rd_word;
                push       = 1'b1;
                nxt_state  = ST_FIN;
            end
            ST_FIN:
            begin
                nxt_head   = pend_inv_ff ? ~second_ff : second_ff;
                nxt_second = stk_top;
                pop        = 1'b1;
                nxt_state  = ST_IDLE;
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    // --------------------------------------------------
    // registers
    // --------------------------------------------------
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            head_ff     <= 16'h0000;
            second_ff   <= 16'h0000;
            state_ff    <= ST_IDLE;
            pend_op_ff  <= `SOD_OP_NOP;
            pend_inv_ff <= 1'b0;
        end
        else
        begin
            head_ff   <= (reg_wr && reg_addr == `SOD_REG_HEAD && !busy && !op_valid)
                         ? reg_wdata : nxt_head;
            second_ff <= (reg_wr && reg_addr == `SOD_REG_SECOND && !busy && !op_valid)
                         ? reg_wdata : nxt_second;
            state_ff  <= nxt_state;
            if (issue && is_load)
            begin
                pend_op_ff  <= op_code;
                pend_inv_ff <= inv;
            end
        end
    end

    // --------------------------------------------------
    // bus strobes, one cycle each
    // --------------------------------------------------
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            mem_addr_ff   <= 16'h0000;
            mem_wdata_ff  <= 16'h0000;
            mem_rd_ff     <= 1'b0;
            mem_wr_ff     <= 1'b0;
            mem_byte_ff   <= 1'b0;
            xbus_addr_ff  <= 5'h00;
            xbus_wdata_ff <= 16'h0000;
            xbus_rd_ff    <= 1'b0;
            xbus_wr_ff    <= 1'b0;
            usr_addr_ff   <= 5'h00;
            usr_wdata_ff  <= 16'h0000;
            usr_rd_ff     <= 1'b0;
            usr_wr_ff     <= 1'b0;
        end
        else
        begin
            mem_rd_ff  <= issue && op_code == `SOD_OP_MEM_LOAD;
            mem_wr_ff  <= issue && op_code == `SOD_OP_MEM_STORE;
            xbus_rd_ff <= issue && op_code == `SOD_OP_XBUS_LOAD;
            xbus_wr_ff <= issue && op_code == `SOD_OP_XBUS_STORE;
            usr_rd_ff  <= issue && op_code == `SOD_OP_USR_LOAD;
            usr_wr_ff  <= issue && op_code == `SOD_OP_USR_STORE;
            if (issue)
            begin
                mem_addr_ff   <= head_ff;
                mem_wdata_ff  <= second_ff;
                mem_byte_ff   <= instr[`SOD_BYTE_BIT];
                xbus_addr_ff  <= instr[`SOD_ADDR_MSB:0];
                xbus_wdata_ff <= head_ff;
                usr_addr_ff   <= instr[`SOD_ADDR_MSB:0];
                usr_wdata_ff  <= head_ff;
            end
        end
    end

    // --------------------------------------------------
    // return sequencing
    // --------------------------------------------------
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            ret_req_ff                  <= 1'b0;
            ret_pop_ff                  <= 1'b0;
            pc_from_index_ff            <= 1'b0;
            page_from_saved_page_reg_ff <= 1'b0;
        end
        else
        begin
            ret_req_ff                  <= issue && instr[`SOD_RET_BIT];
            ret_pop_ff                  <= issue && instr[`SOD_RET_BIT];
            pc_from_index_ff            <= issue && instr[`SOD_RET_BIT];
            page_from_saved_page_reg_ff <= issue && instr[`SOD_RET_BIT];
        end
    end

    // --------------------------------------------------
    // register port
    // --------------------------------------------------
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            ctrl_ff      <= `SOD_CTRL_RST;
            op_count_ff  <= 16'h0000;
            reg_rdata_ff <= 16'h0000;
        end
        else
        begin
            if (reg_wr && reg_addr == `SOD_REG_CTRL)
                ctrl_ff <= reg_wdata;
            if (issue)
                op_count_ff <= op_count_ff + 16'h0001;
            case (reg_addr)
                `SOD_REG_CTRL:   reg_rdata_ff <= reg_rd ? ctrl_ff : 16'h0000;
                `SOD_REG_HEAD:   reg_rdata_ff <= reg_rd ? head_ff : 16'h0000;
                `SOD_REG_SECOND: reg_rdata_ff <= reg_rd ? second_ff : 16'h0000;
                `SOD_REG_DEPTH:  reg_rdata_ff <= reg_rd ? {7'h00, stk_depth} : 16'h0000;
                `SOD_REG_STATUS: reg_rdata_ff <= reg_rd ? op_count_ff : 16'h0000;
                default:         reg_rdata_ff <= 16'h0000;
            endcase
        end
    end
endmodule

// ---- testbench/sod_dp_asserts.sv ----
// port assertions for the stack operand datapath
`timescale 1ns/1ps
`include "sod_consts.vh"
module sod_dp_asserts (
    // clock, reset and issue
    input wire        clk,
    input wire        sys_rst,
    input wire        op_valid,
    input wire [3:0]  op_code,
    input wire [15:0] instr,
    // memory sides
    input wire [15:0] mem_addr_ff,
    input wire [15:0] mem_wdata_ff,
    input wire        mem_rd_ff,
    input wire        mem_wr_ff,
    input wire        mem_byte_ff,
    input wire [15:0] mem_rdata,
    input wire [4:0]  xbus_addr_ff,
    input wire [15:0] xbus_wdata_ff,
    input wire        xbus_rd_ff,
    input wire        xbus_wr_ff,
    input wire [4:0]  usr_addr_ff,
    input wire [15:0] usr_wdata_ff,
    input wire        usr_rd_ff,
    input wire        usr_wr_ff,
    // units, return and state
    input wire [3:0]  alu_c,
    input wire [2:0]  alu_a,
    input wire [3:0]  shift_sel,
    input wire        ret_req_ff,
    input wire        ret_pop_ff,
    input wire        pc_from_index_ff,
    input wire        page_from_saved_page_reg_ff,
    input wire        busy,
    input wire [15:0] head,
    input wire [15:0] second
);
    wire       acc = op_valid && !busy;
    wire [4:0] fld = instr[4:0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_mem_load_addr: assert property (
        acc && op_code == `SOD_OP_MEM_LOAD |=> mem_rd_ff && busy && mem_addr_ff == $past(head))
        else $error("memory load strobe or address wrong");
    a_load_via_second: assert property (
        acc && op_code == `SOD_OP_MEM_LOAD
        |=> ##1 second == $past(mem_rdata)
        ##1 head == ($past(instr[8], 3) ? ~$past(second) : $past(second)))
        else $error("load data did not pass through second");
    a_mem_store_data: assert property (
        acc && op_code == `SOD_OP_MEM_STORE
        |=> mem_wr_ff && mem_byte_ff == $past(instr[12])
        && mem_addr_ff == $past(head) && mem_wdata_ff == $past(second))
        else $error("memory store wrong");
    a_xbus_load_addr: assert property (
        acc && op_code == `SOD_OP_XBUS_LOAD |=> xbus_rd_ff && xbus_addr_ff == $past(fld))
        else $error("bus load wrong");
    a_xbus_store_data: assert property (
        acc && op_code == `SOD_OP_XBUS_STORE
        |=> xbus_wr_ff && xbus_addr_ff == $past(fld) && xbus_wdata_ff == $past(head))
        else $error("bus store wrong");
    a_usr_load_addr: assert property (
        acc && op_code == `SOD_OP_USR_LOAD |=> usr_rd_ff && usr_addr_ff == $past(fld))
        else $error("user load wrong");
    a_usr_store_data: assert property (
        acc && op_code == `SOD_OP_USR_STORE
        |=> usr_wr_ff && usr_addr_ff == $past(fld) && usr_wdata_ff == $past(head))
        else $error("user store wrong");
    a_exchange_swap: assert property (
        acc && op_code == `SOD_OP_EXCHANGE && !instr[8]
        |=> head == $past(second) && second == $past(head))
        else $error("exchange wrong");
    a_ret_pulse: assert property (
        acc && instr[5] |=> ret_req_ff && ret_pop_ff && pc_from_index_ff
        && page_from_saved_page_reg_ff ##1 !ret_req_ff)
        else $error("return pulses wrong");
    a_unit_fields: assert property (
        alu_c == instr[12:9] && alu_a == instr[8:6] && shift_sel == instr[3:0])
        else $error("unit select fields wrong");
    c_mem_load: cover property (acc && op_code == `SOD_OP_MEM_LOAD);
    c_ret: cover property (acc && instr[5]);
    c_refused: cover property (op_valid && busy);
endmodule
bind sod_datapath sod_dp_asserts i_chk (.*);

// ---- testbench/sod_mem_model.sv ----
// main memory, extension bus and user space model
`timescale 1ns/1ps
module sod_mem_model (
    input  wire        clk,
    input  wire [15:0] mem_addr_ff,
    input  wire [15:0] mem_wdata_ff,
    input  wire        mem_rd_ff,
    input  wire        mem_wr_ff,
    output wire [15:0] mem_rdata,
    input  wire [4:0]  xbus_addr_ff,
    input  wire [15:0] xbus_wdata_ff,
    input  wire        xbus_rd_ff,
    input  wire        xbus_wr_ff,
    output wire [15:0] xbus_rdata,
    input  wire [4:0]  usr_addr_ff,
    input  wire [15:0] usr_wdata_ff,
    input  wire        usr_rd_ff,
    input  wire        usr_wr_ff,
    output wire [15:0] usr_rdata
);
    logic [15:0] mem_q [0:255];
    logic [15:0] xbus_q [0:31];
    logic [15:0] usr_q [0:31];
    logic [15:0] mem_last = 16'h0000;
    logic [15:0] xbus_last = 16'h0000;
    logic [15:0] usr_last = 16'h0000;
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem_q[i] = 16'h0000;
        for (int i = 0; i < 32; i++)
        begin
            xbus_q[i] = 16'h0000;
            usr_q[i] = 16'h0000;
        end
    end
    // idle data lines toggle so stale values never look valid
    assign mem_rdata = mem_rd_ff ? mem_q[mem_addr_ff[7:0]] : ~mem_last;
    assign xbus_rdata = xbus_rd_ff ? xbus_q[xbus_addr_ff] : ~xbus_last;
    assign usr_rdata = usr_rd_ff ? usr_q[usr_addr_ff] : ~usr_last;
    always @(posedge clk)
    begin
        if (mem_wr_ff) mem_q[mem_addr_ff[7:0]] <= mem_wdata_ff;
        if (xbus_wr_ff) xbus_q[xbus_addr_ff] <= xbus_wdata_ff;
        if (usr_wr_ff) usr_q[usr_addr_ff] <= usr_wdata_ff;
        mem_last <= mem_rdata;
        xbus_last <= xbus_rdata;
        usr_last <= usr_rdata;
    end
endmodule

// ---- testbench/stack_operand_datapath_test.sv ----
// self-checking bench for the stack operand datapath
`timescale 1ns/1ps
`include "sod_consts.vh"
module stack_operand_datapath_test;
    logic        clk, sys_rst, op_valid, mem_rd_ff, mem_wr_ff, mem_byte_ff, busy;
    logic        xbus_rd_ff, xbus_wr_ff, usr_rd_ff, usr_wr_ff, reg_wr, reg_rd;
    logic        ret_req_ff, ret_pop_ff, pc_from_index_ff, page_from_saved_page_reg_ff;
    logic [3:0]  op_code, alu_c, shift_sel, reg_addr;
    logic [2:0]  alu_a;
    logic [4:0]  xbus_addr_ff, usr_addr_ff, g;
    logic [15:0] instr, long_lit, mem_addr_ff, mem_wdata_ff, mem_rdata, xbus_wdata_ff;
    logic [15:0] xbus_rdata, usr_wdata_ff, usr_rdata, alu_result, shift_head, shift_second;
    logic [15:0] reg_wdata, reg_rdata_ff, head, second, v, t;
    logic [15:0] m_head, m_second, m_mem [0:31], m_x [0:31], m_u [0:31];
    logic [15:0] m_stk [$];
    int          err_total, comparisons, m_ops;
    sod_datapath i_dut (.*);
    sod_mem_model i_mem (.*);
    always #5 clk = ~clk;
    // unit results hold still while an operation is offered
    always @(posedge clk)
    begin
        if (!op_valid)
        begin
            alu_result <= $urandom;
            shift_head <= $urandom;
            shift_second <= $urandom;
        end
    end
    // --------------------------------------------------
    // compare, model and bus tasks
    // --------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic m_push(input logic [15:0] d);
        m_stk.push_back(m_second);
        m_second = m_head;
        m_head = d;
    endtask
    task automatic m_pop();
        m_head = m_second;
        m_second = (m_stk.size() > 0) ? m_stk.pop_back() : 16'h0000;
    endtask
    task automatic reg_io(input logic [3:0] a, input logic [15:0] d, input logic w,
                          input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge clk);
        if (!w) chk(reg_rdata_ff, exp);
    endtask
    // hold above one keeps op_valid up while busy, which must be ignored
    task automatic step(input logic [3:0] op, input logic [15:0] ins, input logic [15:0] lit,
                        input int hold);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= op;
        instr <= ins;
        long_lit <= lit;
        repeat (hold) @(posedge clk);
        op_valid <= 1'b0;
        m_ops++;
        @(negedge clk);
        if (op == `SOD_OP_ALU)
            m_head = ins[`SOD_INV_BIT] ? ~alu_result : alu_result;
        if (op == `SOD_OP_SHIFT)
        begin
            m_head = shift_head;
            m_second = shift_second;
        end
        chk(head, m_head);
        chk(second, m_second);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        #20000;
        err_total++;
        end_of_test();
    end
    // --------------------------------------------------
    // main sequence
    // --------------------------------------------------
    initial
    begin
        {clk, op_valid, op_code, instr, long_lit, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {alu_result, shift_head, shift_second, m_head, m_second, m_ops} = '0;
        sys_rst = 1'b1;
        void'($urandom(9));
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        reg_io(`SOD_REG_CTRL, 0, 0, `SOD_CTRL_RST);
        reg_io(`SOD_REG_DEPTH, 0, 0, 16'h0000);
        reg_io(4'hf, 0, 0, 16'h0000);
        v = $urandom;
        reg_io(`SOD_REG_CTRL, v, 1, 0);
        reg_io(`SOD_REG_CTRL, 0, 0, v);
        v = $urandom;
        m_second = v;
        reg_io(`SOD_REG_SECOND, v, 1, 0);
        v = $urandom;
        m_head = v;
        reg_io(`SOD_REG_HEAD, v, 1, 0);
        for (int i = 0; i < 6; i++)
        begin
            v = (i == 0) ? 16'h001f : (i == 1) ? 16'h0000 : 16'($urandom_range(31));
            m_push(v);
            step(`SOD_OP_SHORT_LIT, {10'h0, 1'($urandom), v[4:0]}, 0, 1);
        end
        v = $urandom;
        m_push(v);
        step(`SOD_OP_LONG_LIT, 0, v, 1);
        t = m_head;
        m_head = m_second;
        m_second = t;
        step(`SOD_OP_EXCHANGE, 0, 0, 1);
        m_stk.push_back(m_second);
        m_second = m_head;
        step(`SOD_OP_DUPLICATE, 0, 0, 1);
        t = m_second;
        m_push(t);
        step(`SOD_OP_OVER, 0, 0, 1);
        m_pop();
        step(`SOD_OP_DISCARD, 0, 0, 1);
        reg_io(`SOD_REG_DEPTH, 0, 0, 16'(m_stk.size()));
        m_head = ~m_head;
        step(`SOD_OP_NOP, 16'h0100, 0, 1);
        m_push(16'h0011);
        step(`SOD_OP_SHORT_LIT, 16'h0011, 0, 1);
        m_mem[17] = m_second;
        m_pop();
        step(`SOD_OP_MEM_STORE, 0, 0, 1);
        g = 5'($urandom);
        m_x[g] = m_head;
        m_pop();
        step(`SOD_OP_XBUS_STORE, {11'h0, g}, 0, 1);
        m_u[~g] = m_head;
        m_pop();
        step(`SOD_OP_USR_STORE, {11'h0, ~g}, 0, 1);
        reg_io(`SOD_REG_STATUS, 0, 0, 16'(m_ops));
        m_push(16'h0011);
        step(`SOD_OP_SHORT_LIT, 16'h0011, 0, 1);
        m_head = ~m_mem[17];
        step(`SOD_OP_MEM_LOAD, 16'h0100, 0, 3);
        m_head = m_x[g];
        step(`SOD_OP_XBUS_LOAD, {11'h0, g}, 0, 3);
        m_head = m_u[~g];
        step(`SOD_OP_USR_LOAD, {11'h0, ~g}, 0, 3);
        step(`SOD_OP_ALU, 16'($urandom), 0, 1);
        step(`SOD_OP_SHIFT, 16'($urandom), 0, 1);
        reg_io(`SOD_REG_DEPTH, 0, 0, 16'(m_stk.size()));
        end_of_test();
    end
endmodule
